/* File: hw/system_bus_arb.sv */
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// - drive bus-init error on fatal condition, if enabled
// - observed bus-init resets lock and arbitration state
// - bus-init leaves queue and tracking state intact
// - after bus-init, re-arbitrate and finish pending work
// - agent unable to accept asserts stall-next-request
// - no new transactions while bus is stalled
// - refuse operation while platform select is low
// - six monitor lines; lines 0-3 report breakpoint status
// - monitor line four is debug-ready output
// - priority request blocks new non-locked requests
// - bus request line drives system request zero
// - sample bus request at config for agent id
// - drive frequency select; all agents same frequency
// - everything driven and sampled on rising clock
module system_bus_arb #(
	parameter logic [system_bus_arb_pkg::AGENT_ID_W-1:0] ALT_AGENT_ID = 2'h1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [system_bus_arb_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [system_bus_arb_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [system_bus_arb_pkg::DATA_W-1:0] reg_rdata,
	output logic irq,
	input wire logic cfg_init_drive_en,
	input wire logic cfg_init_observe_en,
	input wire logic platform_support_select,
	input wire system_bus_arb_pkg::core_req_s core_req,
	output system_bus_arb_pkg::core_rsp_s core_rsp,
	input wire logic arb_win,
	input wire logic [3:0] breakpoint_status,
	input wire logic core_debug_ready,
	input wire logic bus_init_error_in_n,
	output logic bus_init_error_out_n,
	output logic bus_init_error_oe,
	input wire logic stall_next_request_in_n,
	output logic stall_next_request_out_n,
	output logic stall_next_request_oe,
	input wire logic symmetric_bus_request_in_n,
	output logic symmetric_bus_request_out_n,
	output logic symmetric_bus_request_oe,
	input wire logic priority_agent_request_n,
	input wire logic [system_bus_arb_pkg::BP_LINES-1:0] breakpoint_monitor_lines_in_n,
	output logic [system_bus_arb_pkg::BP_LINES-1:0] breakpoint_monitor_lines_out_n,
	output logic [system_bus_arb_pkg::BP_LINES-1:0] breakpoint_monitor_lines_oe,
	output logic [system_bus_arb_pkg::FREQ_W-1:0] clock_frequency_select
);
	import system_bus_arb_pkg::*;

	// both ids equal would make the configuration strap meaningless
	if (ALT_AGENT_ID == AGENT_ID_SELF) begin : g_bad_agent_id
		$error("alternate agent id must differ from own id");
	end

	localparam logic [7:0] INIT_HOLD = 8'(INIT_HOLD_CYCLES);

	// power-on configuration, caught in the first cycle after reset; platform select resampled every cycle
	logic cfg_done, next_cfg_done;
	logic drive_en, next_drive_en;
	logic observe_en, next_observe_en;
	logic [AGENT_ID_W-1:0] agent_id, next_agent_id;
	logic platform_ok, next_platform_ok;

	always_comb begin
		next_cfg_done = 1'b1;
		next_drive_en = drive_en;
		next_observe_en = observe_en;
		next_agent_id = agent_id;
		next_platform_ok = platform_support_select;
		if (!cfg_done) begin
			next_drive_en = cfg_init_drive_en;
			next_observe_en = cfg_init_observe_en;
			// own request pin low at configuration means agent 0
			next_agent_id = !symmetric_bus_request_in_n ? AGENT_ID_SELF : ALT_AGENT_ID;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg_done <= 1'b0;
			drive_en <= 1'b0;
			observe_en <= 1'b0;
			agent_id <= AGENT_ID_SELF;
			platform_ok <= 1'b0;
		end else begin
			cfg_done <= next_cfg_done;
			drive_en <= next_drive_en;
			observe_en <= next_observe_en;
			agent_id <= next_agent_id;
			platform_ok <= next_platform_ok;
		end
	end

	logic operate;
	assign operate = cfg_done && platform_ok;

	// sampled bus pins, turned to active-high meaning
	logic init_seen_pin, stall_seen, prio_seen, dbg_req_seen;
	logic next_init_seen_pin, next_stall_seen, next_prio_seen, next_dbg_req_seen;
	arb_state_e arb_state, next_arb_state;
	logic locked, next_locked;
	logic [7:0] init_cnt, next_init_cnt;
	logic next_grant;
	logic init_obs;
	logic init_drv, stall_drv, req_drv;
	logic [DATA_W-1:0] ctrl, next_ctrl;
	logic [BP_LINES-1:0] bp_assert;

	// observation gated by strap; with it off the pin is left to a central agent
	assign init_obs = observe_en && init_seen_pin;

	always_comb begin
		next_init_seen_pin = !bus_init_error_in_n;
		next_stall_seen = !stall_next_request_in_n;
		next_prio_seen = !priority_agent_request_n;
		next_dbg_req_seen = !breakpoint_monitor_lines_in_n[BP_REQUEST_LINE];
		next_arb_state = arb_state;
		next_locked = locked;
		next_init_cnt = init_cnt;
		case (arb_state)
			ARB_IDLE: begin
				if (operate && core_req.pending) begin
					next_arb_state = ARB_REQ;
				end
			end
			ARB_REQ: begin
				if (!core_req.pending) begin
					next_arb_state = ARB_IDLE;
				end else if (arb_win) begin
					next_arb_state = ARB_OWN;
				end
			end
			ARB_OWN: begin
				if (!core_req.pending) begin
					next_arb_state = ARB_IDLE;
				end
			end
			default: begin
				next_arb_state = ARB_IDLE;
			end
		endcase
		if (core_req.lock_start) begin
			next_locked = 1'b1;
		end
		if (core_req.lock_end) begin
			next_locked = 1'b0;
		end
		// pending work survives in the core; only arbitration and the lock restart
		if (init_obs || !operate) begin
			next_arb_state = ARB_IDLE;
			next_locked = 1'b0;
		end
		if (init_cnt != 8'h00) begin
			next_init_cnt = init_cnt - 8'h01;
		end
		if (operate && drive_en && core_req.fatal_error) begin
			next_init_cnt = INIT_HOLD;
		end
		// locked sequences may still go out under a priority request
		next_grant = operate && !init_obs && arb_state == ARB_OWN && core_req.issue
			&& !stall_seen && (!prio_seen || locked);
	end

	assign init_drv = (next_init_cnt != 8'h00);
	assign stall_drv = operate && (core_req.not_ready || ctrl[CTRL_FORCE_STALL]);
	assign req_drv = (next_arb_state != ARB_IDLE);
	assign bp_assert = {1'b0, core_debug_ready && operate, breakpoint_status};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			init_seen_pin <= 1'b0;
			stall_seen <= 1'b0;
			prio_seen <= 1'b0;
			dbg_req_seen <= 1'b0;
			arb_state <= ARB_IDLE;
			locked <= 1'b0;
			init_cnt <= 8'h00;
			bus_init_error_out_n <= 1'b1;
			bus_init_error_oe <= 1'b0;
			stall_next_request_out_n <= 1'b1;
			stall_next_request_oe <= 1'b0;
			symmetric_bus_request_out_n <= 1'b1;
			symmetric_bus_request_oe <= 1'b0;
			breakpoint_monitor_lines_out_n <= {BP_LINES{1'b1}};
			breakpoint_monitor_lines_oe <= {BP_LINES{1'b0}};
			core_rsp <= '0;
		end else begin
			init_seen_pin <= next_init_seen_pin;
			stall_seen <= next_stall_seen;
			prio_seen <= next_prio_seen;
			dbg_req_seen <= next_dbg_req_seen;
			arb_state <= next_arb_state;
			locked <= next_locked;
			init_cnt <= next_init_cnt;
			// open-drain style: pull low and enable together
			bus_init_error_out_n <= !init_drv;
			bus_init_error_oe <= init_drv;
			stall_next_request_out_n <= !stall_drv;
			stall_next_request_oe <= stall_drv;
			symmetric_bus_request_out_n <= !req_drv;
			symmetric_bus_request_oe <= req_drv;
			breakpoint_monitor_lines_out_n <= ~bp_assert;
			breakpoint_monitor_lines_oe <= bp_assert;
			core_rsp.grant <= next_grant;
			core_rsp.debug_request <= next_dbg_req_seen && operate;
			core_rsp.init_seen <= init_obs;
		end
	end

	// register file
	logic [EV_W-1:0] event_st, next_event_st;
	logic [EV_W-1:0] mask, next_mask;
	logic [DATA_W-1:0] next_rdata;
	logic next_irq;
	logic [EV_W-1:0] ev_set;
	logic [DATA_W-1:0] state_word;

	always_comb begin
		state_word = '0;
		state_word[ST_PLATFORM_OK] = platform_ok;
		state_word[ST_DRIVE_EN] = drive_en;
		state_word[ST_OBSERVE_EN] = observe_en;
		state_word[ST_AGENT_LSB +: AGENT_ID_W] = agent_id;
		state_word[ST_LOCKED] = locked;
		state_word[ST_STALL] = stall_seen;
		state_word[ST_PRIORITY] = prio_seen;
		state_word[ST_ARB_LSB +: 2] = arb_state;
		ev_set = '0;
		ev_set[EV_INIT_SEEN] = init_obs;
		ev_set[EV_INIT_DRIVEN] = operate && drive_en && core_req.fatal_error;
		ev_set[EV_DEBUG_REQ] = dbg_req_seen && operate;
		ev_set[EV_REFUSED] = cfg_done && !platform_ok && core_req.pending;
		next_ctrl = ctrl;
		next_mask = mask;
		next_event_st = event_st;
		next_rdata = '0;
		if (reg_wr) begin
			case (reg_addr)
				OFF_CTRL: next_ctrl = {29'h0, reg_wdata[2:0]};
				OFF_MASK: next_mask = reg_wdata[EV_W-1:0];
				OFF_EVENT: next_event_st = event_st & ~reg_wdata[EV_W-1:0];
				default: next_ctrl = ctrl;
			endcase
		end
		// a new event beats a clear in the same cycle
		next_event_st = next_event_st | ev_set;
		if (reg_rd) begin
			case (reg_addr)
				OFF_CTRL: next_rdata = ctrl;
				OFF_STATE: next_rdata = state_word;
				OFF_EVENT: next_rdata = {28'h0, event_st};
				OFF_MASK: next_rdata = {28'h0, mask};
				default: next_rdata = '0;
			endcase
		end
		next_irq = |(next_event_st & next_mask);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl <= {30'h0, FREQ_SEL_RST};
			event_st <= EVENT_RST;
			mask <= MASK_RST;
			reg_rdata <= '0;
			irq <= 1'b0;
			clock_frequency_select <= FREQ_SEL_RST;
		end else begin
			ctrl <= next_ctrl;
			event_st <= next_event_st;
			mask <= next_mask;
			reg_rdata <= next_rdata;
			irq <= next_irq;
			clock_frequency_select <= next_ctrl[CTRL_FREQ_LSB +: FREQ_W];
		end
	end

	a_init_drive: assert property (@(posedge sys_clk) disable iff (rst)
		operate && drive_en && core_req.fatal_error |=> bus_init_error_oe [*2]
		##1 (!bus_init_error_oe || $past(core_req.fatal_error)
		|| $past(core_req.fatal_error, 2)))
		else $error("bus init error not driven for the hold time");
	a_init_gated: assert property (@(posedge sys_clk) disable iff (rst)
		!drive_en && cfg_done |=> !bus_init_error_oe)
		else $error("bus init error driven while driver disabled");
	a_init_resets_arb: assert property (@(posedge sys_clk) disable iff (rst)
		init_obs |=> arb_state == ARB_IDLE && !locked && !core_rsp.grant)
		else $error("arbitration not reset by bus init");
	a_rearbitrate: assert property (@(posedge sys_clk) disable iff (rst)
		init_obs ##1 !init_obs && operate && core_req.pending |=> symmetric_bus_request_oe)
		else $error("no re-arbitration after bus init");
	a_stall_blocks: assert property (@(posedge sys_clk) disable iff (rst)
		stall_seen |=> !core_rsp.grant)
		else $error("grant issued during bus stall");
	a_stall_drive: assert property (@(posedge sys_clk) disable iff (rst)
		operate && core_req.not_ready |=> !stall_next_request_out_n)
		else $error("stall not asserted when not ready");
	a_platform_refuse: assert property (@(posedge sys_clk) disable iff (rst)
		!platform_support_select ##1 1'b1 |=> !symmetric_bus_request_oe && !core_rsp.grant)
		else $error("operating on unsupported platform");
	a_priority_blocks: assert property (@(posedge sys_clk) disable iff (rst)
		prio_seen && !locked |=> !core_rsp.grant)
		else $error("new request issued under priority request");
	a_debug_ready: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(core_debug_ready) && operate |=> !breakpoint_monitor_lines_out_n[BP_READY_LINE])
		else $error("debug ready not shown on line four");
	a_agent_id: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_done && !symmetric_bus_request_in_n |=> agent_id == AGENT_ID_SELF)
		else $error("agent id not taken from request pin");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
		irq == |(event_st & mask))
		else $error("interrupt level disagrees with status");
endmodule // system_bus_arb

/* File: hw/system_bus_arb_pkg.sv */
package system_bus_arb_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// register offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATE = 4'h4;
	localparam logic [3:0] OFF_EVENT = 4'h8;
	localparam logic [3:0] OFF_MASK = 4'hC;
	// control fields
	localparam int CTRL_FREQ_LSB = 0;
	localparam int FREQ_W = 2;
	localparam int CTRL_FORCE_STALL = 2;
	localparam logic [FREQ_W-1:0] FREQ_SEL_RST = 2'h0;
	// state fields
	localparam int ST_PLATFORM_OK = 0;
	localparam int ST_DRIVE_EN = 1;
	localparam int ST_OBSERVE_EN = 2;
	localparam int ST_AGENT_LSB = 3;
	localparam int ST_LOCKED = 5;
	localparam int ST_STALL = 6;
	localparam int ST_PRIORITY = 7;
	localparam int ST_ARB_LSB = 8;
	// event and mask fields
	localparam int EV_W = 4;
	localparam int EV_INIT_SEEN = 0;
	localparam int EV_INIT_DRIVEN = 1;
	localparam int EV_DEBUG_REQ = 2;
	localparam int EV_REFUSED = 3;
	localparam logic [EV_W-1:0] EVENT_RST = 4'h0;
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;
	// agent identity, bus-init pulse length and monitor lines
	localparam int AGENT_ID_W = 2;
	localparam logic [AGENT_ID_W-1:0] AGENT_ID_SELF = 2'h0;
	localparam int INIT_HOLD_CYCLES = 2;
	localparam int BP_LINES = 6;
	localparam int BP_READY_LINE = 4;
	localparam int BP_REQUEST_LINE = 5;

	typedef enum logic [1:0] {ARB_IDLE, ARB_REQ, ARB_OWN} arb_state_e;

	typedef struct packed {
		logic pending;
		logic issue;
		logic lock_start;
		logic lock_end;
		logic not_ready;
		logic fatal_error;
	} core_req_s;

	typedef struct packed {
		logic grant;
		logic debug_request;
		logic init_seen;
	} core_rsp_s;
endpackage

/* File: bench/bus_agents_model.sv */
`timescale 1ns/1ns
module bus_agents_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic [3:0] prio_jobs,
	input wire logic stall_cmd,
	input wire logic dbg_cmd,
	input wire logic req_n,
	input wire logic strap_off,
	input wire logic init_cmd,
	output logic init_lo,
	output logic arb_win,
	output logic prio_n,
	output logic stall_lo,
	output logic dbg_lo,
	output logic strap_lo
);
	logic [3:0] jobs;
	logic [1:0] waited;
	// the priority agent holds on until its own queue has drained, then lets go
	assign prio_n = (jobs == 4'h0);
	always @(posedge sys_clk) begin
		strap_lo <= rst & ~strap_off;
		// another agent signalling bus init, seen by a central agent only
		init_lo <= init_cmd & ~rst;
		stall_lo <= stall_cmd & ~rst;
		dbg_lo <= dbg_cmd & ~rst;
		if (rst || req_n) begin
			waited <= 2'h0;
			arb_win <= 1'h0;
		end else begin
			waited <= waited + {1'h0, ~arb_win};
			arb_win <= arb_win | (waited >= (slow ? 2'h2 : 2'h0));
		end
		if (rst) begin
			jobs <= 4'h0;
		end else if (jobs != 4'h0) begin
			jobs <= jobs - 4'h1;
		end else begin
			jobs <= prio_jobs;
		end
	end
endmodule // bus_agents_model

/* File: bench/system_bus_arbitration_control_tb_top.sv */
`timescale 1ns/1ns
module system_bus_arbitration_control_tb_top;
	import system_bus_arb_pkg::*;
	logic sys_clk = '0;
	logic rst = '1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = '0;
	logic reg_rd = '0;
	logic platform_support_select = '1;
	core_req_s core_req = '0;
	logic [3:0] breakpoint_status = '0;
	logic core_debug_ready = '0;
	logic slow = '0, stall_cmd = '0, dbg_cmd = '0;
	logic drive_strap = '1, observe_strap = '1, strap_off = '0, init_cmd = '0;
	logic init_lo;
	localparam logic [AGENT_ID_W-1:0] ALT_ID = 2'h2;
	logic [3:0] prio_jobs = '0;
	logic [DATA_W-1:0] reg_rdata;
	logic irq, arb_win, prio_n, stall_lo, dbg_lo, strap_lo;
	core_rsp_s core_rsp;
	logic bi_out_n, bi_oe, sn_out_n, sn_oe, rq_out_n, rq_oe;
	logic [BP_LINES-1:0] bp_out_n, bp_oe;
	logic [FREQ_W-1:0] clock_frequency_select;
	logic [31:0] seed = 32'h76BC;
	logic [31:0] v;
	int err_total = 0;
	int cmp_count = 0;
	// terminated lines: low when any party pulls, high otherwise
	wire logic bi_n = ~((bi_oe & ~bi_out_n) | init_lo);
	wire logic sn_n = ~((sn_oe & ~sn_out_n) | stall_lo);
	wire logic rq_n = ~((rq_oe & ~rq_out_n) | strap_lo);
	wire logic [BP_LINES-1:0] bp_n = ~((bp_oe & ~bp_out_n) | {dbg_lo, 5'h00});

	always #2 sys_clk = ~sys_clk;

	system_bus_arb #(.ALT_AGENT_ID(ALT_ID)) uut (
		.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.cfg_init_drive_en(drive_strap),
		.cfg_init_observe_en(observe_strap),
		.platform_support_select, .core_req, .core_rsp, .arb_win,
		.breakpoint_status, .core_debug_ready,
		.bus_init_error_in_n(bi_n),
		.bus_init_error_out_n(bi_out_n),
		.bus_init_error_oe(bi_oe),
		.stall_next_request_in_n(sn_n),
		.stall_next_request_out_n(sn_out_n),
		.stall_next_request_oe(sn_oe),
		.symmetric_bus_request_in_n(rq_n),
		.symmetric_bus_request_out_n(rq_out_n),
		.symmetric_bus_request_oe(rq_oe),
		.priority_agent_request_n(prio_n),
		.breakpoint_monitor_lines_in_n(bp_n),
		.breakpoint_monitor_lines_out_n(bp_out_n),
		.breakpoint_monitor_lines_oe(bp_oe),
		.clock_frequency_select
	);

	bus_agents_model agents (
		.sys_clk, .rst, .slow, .prio_jobs, .stall_cmd, .dbg_cmd,
		.req_n(rq_n), .strap_off, .init_cmd, .init_lo,
		.arb_win, .prio_n, .stall_lo, .dbg_lo, .strap_lo
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] state_idle();
		return (32'h1 << ST_PLATFORM_OK) | (32'h1 << ST_DRIVE_EN) | (32'h1 << ST_OBSERVE_EN)
			| (32'(AGENT_ID_SELF) << ST_AGENT_LSB);
	endfunction

	task automatic end_of_test();
		$display("mismatches %0d of %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= '1;
		@(posedge sys_clk);
		reg_wr <= '0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= '1;
		@(posedge sys_clk);
		reg_rd <= '0;
		#1 chk(reg_rdata, e);
	endtask

	// a missing grant ends the run early, since later steps all lean on it
	task automatic wait_grant(input logic exp);
		logic seen;
		seen = '0;
		repeat (12) begin
			@(posedge sys_clk);
			#1 seen |= core_rsp.grant;
		end
		chk(32'(seen), 32'(exp));
		if (exp && !seen) end_of_test();
	endtask

	initial begin
		#200000;
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= '0;
		rd(OFF_CTRL, 32'h0);
		rd(OFF_EVENT, 32'h0);
		rd(OFF_MASK, 32'h0);
		rd(4'h2, 32'h0);
		rd(OFF_STATE, state_idle());
		wr(OFF_STATE, 32'hFFFFFFFF);
		rd(OFF_STATE, state_idle());
		repeat (6) begin
			v = rnd();
			wr(OFF_CTRL, v & 32'h3);
			breakpoint_status <= v[7:4];
			core_debug_ready <= v[8];
			repeat (2) @(posedge sys_clk);
			#1 chk(32'(clock_frequency_select), v & 32'h3);
			chk(32'(bp_n[4:0] ^ 5'h1F), 32'(v[8:4]));
			chk(32'(bp_oe[BP_REQUEST_LINE]), 32'h0);
		end
		@(posedge sys_clk);
		dbg_cmd <= '1;
		repeat (4) @(posedge sys_clk);
		#1 chk(32'(core_rsp.debug_request), 32'h1);
		chk(32'(irq), 32'h0);
		wr(OFF_MASK, 32'hF);
		dbg_cmd <= '0;
		repeat (2) @(posedge sys_clk);
		#1 chk(32'(irq), 32'h1);
		rd(OFF_EVENT, 32'h1 << EV_DEBUG_REQ);
		wr(OFF_EVENT, 32'h1 << EV_DEBUG_REQ);
		repeat (2) @(posedge sys_clk);
		#1 chk(32'(irq), 32'h0);
		@(posedge sys_clk);
		core_req.pending <= '1;
		core_req.issue <= '1;
		wait_grant('1);
		chk(32'(rq_oe & ~rq_out_n), 32'h1);
		for (int lk = 0; lk < 2; lk++) begin
			@(posedge sys_clk);
			slow <= lk[0];
			core_req.lock_start <= lk[0];
			prio_jobs <= 4'hF;
			@(posedge sys_clk);
			core_req.lock_start <= '0;
			prio_jobs <= '0;
			repeat (2) @(posedge sys_clk);
			wait_grant(lk[0]);
			@(posedge sys_clk);
			core_req.lock_end <= lk[0];
			@(posedge sys_clk);
			core_req.lock_end <= '0;
			wait_grant('1);
		end
		@(posedge sys_clk);
		stall_cmd <= '1;
		repeat (3) @(posedge sys_clk);
		wait_grant('0);
		@(posedge sys_clk);
		stall_cmd <= '0;
		core_req.not_ready <= '1;
		repeat (2) @(posedge sys_clk);
		#1 chk(32'(sn_oe & ~sn_out_n), 32'h1);
		@(posedge sys_clk);
		core_req.not_ready <= '0;
		core_req.fatal_error <= '1;
		@(posedge sys_clk);
		core_req.fatal_error <= '0;
		for (int i = 0; i < 3; i++) begin
			#1 chk(32'(bi_oe & ~bi_out_n), 32'(i < INIT_HOLD_CYCLES));
			@(posedge sys_clk);
		end
		#1 chk(32'(core_rsp.init_seen), 32'h1);
		wait_grant('1);
		rd(OFF_EVENT, 32'h3);
		wr(OFF_EVENT, 32'h3);
		platform_support_select <= '0;
		repeat (2) @(posedge sys_clk);
		wait_grant('0);
		@(posedge sys_clk);
		platform_support_select <= '1;
		rd(OFF_EVENT, 32'h1 << EV_REFUSED);
		// second reset: driver and observation off, request pin left high
		@(posedge sys_clk);
		core_req <= '0;
		drive_strap <= '0;
		observe_strap <= '0;
		strap_off <= '1;
		rst <= '1;
		repeat (3) @(posedge sys_clk);
		rst <= '0;
		rd(OFF_STATE, 32'h1 | (32'(ALT_ID) << ST_AGENT_LSB));
		@(posedge sys_clk);
		core_req.pending <= '1;
		core_req.issue <= '1;
		core_req.fatal_error <= '1;
		init_cmd <= '1;
		@(posedge sys_clk);
		core_req.fatal_error <= '0;
		init_cmd <= '0;
		#1 chk(32'(bi_oe), 32'h0);
		wait_grant('1);
		rd(OFF_EVENT, 32'h0);
		@(posedge sys_clk);
		core_req <= '0;
		end_of_test();
	end
endmodule // system_bus_arbitration_control_tb_top
